// ### rtl/ccs_params.svh
// Constants for the clock output select and stop control block
`ifndef CCS_PARAMS_SVH
`define CCS_PARAMS_SVH

// Two-wire target addresses
`define CCS_ADDR_WR   8'hd2
`define CCS_ADDR_RD   8'hd3

// Tri-level select codes from the level comparator
`define CCS_LVL_LO    2'h0
`define CCS_LVL_MID   2'h1
`define CCS_LVL_HI    2'h2

// Low select bits that pick test mode at the middle level
`define CCS_LOW_TEST  2'h1

// Serial control reset values
`define CCS_CTL0_RST  3'h0
`define CCS_CTL1_RST  7'h07
`define CCS_CTL2_RST  8'h7f
`define CCS_CTL3_RST  8'h01

// Field positions in the stored control bytes
`define CCS_C0_SPREAD 2
`define CCS_C0_PDTRI  1
`define CCS_C0_SEL48  0
`define CCS_C2_REFLO  7
`define CCS_C3_STOP   0

// Width of the input synchroniser bank
`define CCS_SYNC_W    16
`endif

// ### rtl/ccs_pkg.sv
// Types shared by the clock output select and stop control block
package ccs_pkg;
  typedef enum logic [1:0] {HF_66, HF_100, HF_200, HF_133} ccs_host_freq_t;
  typedef enum logic [1:0] {MD_BYPASS, MD_FIXED, MD_HIZ, MD_TEST} ccs_mode_t;
  typedef enum logic [2:0] {SM_IDLE, SM_ADDR, SM_CMD, SM_CNT, SM_WDAT, SM_RDAT} ccs_ser_t;
endpackage

// ### rtl/ccs_sync2.sv
// Two-flop synchroniser bank for pins entering the reference clock domain
`timescale 1ns/1ps
`include "ccs_params.svh"
module ccs_sync2 (
  input  wire logic                   ref_clk,
  input  wire logic                   nrst,
  input  wire logic [`CCS_SYNC_W-1:0] d,
  output logic      [`CCS_SYNC_W-1:0] q
);
  logic [`CCS_SYNC_W-1:0] meta_q;

  // First stage feeds only the second stage
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      meta_q <= '0;
      q      <= '0;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule

// ### rtl/ccs_gate.sv
// Glitch-free stop gate for a group of clock outputs sharing one source
`timescale 1ns/1ps
module ccs_gate #(
  parameter int   N        = 1,
  parameter logic STOP_LVL = 1'b0
) (
  input  wire logic         ref_clk,
  input  wire logic         nrst,
  input  wire logic         src,
  input  wire logic [N-1:0] run,
  input  wire logic         frc,
  input  wire logic         frc_val,
  output logic      [N-1:0] out
);
  logic [N-1:0] en_q;

  // Source level and gated value
  wire         at_stop = (src == STOP_LVL);
  wire [N-1:0] gated   = (en_q & {N{src}}) | (~en_q & {N{STOP_LVL}});

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      en_q <= '0;
      out  <= '0;
    end else begin
      if (at_stop) en_q <= run;
      out <= frc ? {N{frc_val}} : gated;
    end
  end

  // Stopped outputs settle to the stop level with no short pulse
  property p_gate_stop;
    @(posedge ref_clk) disable iff (!nrst)
      (!run[0] && at_stop && !frc) ##1 (!run[0] && !frc) |=> out[0] == STOP_LVL;
  endproperty
  AST_GATE_STOP: assert property (p_gate_stop)
    else $error("gated output not at stop level");
endmodule

// ### rtl/ccs_clock_ctrl.sv
// Select decode, select latch, stop and power-down control, two-wire target
`timescale 1ns/1ps
`include "ccs_params.svh"

// Notes on behaviour
// - Low or high tri-level: low select bits choose host clock 66/100/200/133.
// - High tri-level: shared pin is 66 input, buffered copies, PCI at half.
// - Low tri-level: shared pin and buffered outputs fixed 66, PCI fixed 33.
// - Middle level: 00 tri-states all outputs, 01 divides test clock per group.
// - Middle tri-level seen at power-up latches as a 0.
// - Selects and multiplier latch while qualifier is low, held otherwise.
// - Power-down stops all outputs and the PCI divider; serial interface keeps running.
// - PCI stop low holds seven PCI clocks low synchronously; free ones excepted.
// - Three serial bits make each free-capable PCI clock free or stoppable.
// - Host stop holds true halves high and complement halves low.
// - Serial bit picks 48 (1) or 66 (0, default) on selectable output.
// - PCI clocks derive from whichever 66 source is active.
// - Reference output is a buffered copy of the crystal input.
// - USB and dot outputs fixed at 48 outside test and tri-state.
// - Dedicated 66 output fixed outside test and tri-state.
// - Serial data sampled as input, driven open-drain only to ack or send.
// - Target answers only write address D2, read address D3; values retained.
// - Effective PCI stop is AND of pin and internal serial bit.
// - Power-down host: bit 0 true high comp low, bit 1 tri-state.
module ccs_clock_ctrl (
  input  wire logic       ref_clk,
  input  wire logic       nrst,
  input  wire logic       crystal_in,
  input  wire logic       host_pll_clk,
  input  wire logic       pll_66_clk,
  input  wire logic       pll_48_clk,
  input  wire logic [1:0] tri_level_select,
  input  wire logic [1:0] freq_select,
  input  wire logic       current_multiplier_select,
  input  wire logic       select_latch_qualifier_n,
  input  wire logic       power_down_n,
  input  wire logic       host_clock_stop_n,
  input  wire logic       periph_clock_stop_n,
  input  wire logic       serial_clock,
  input  wire logic       serial_data_line_in,
  output logic            serial_data_line_out,
  output logic            serial_data_line_oe,
  input  wire logic       bypass_66_in_or_out_in,
  output logic            bypass_66_in_or_out_out,
  output logic            bypass_66_in_or_out_oe,
  output logic [1:0]      host_freq_code,
  output logic            current_multiplier_latched,
  output logic            spread_enable,
  output logic            ref_low_strength,
  output logic [2:0]      host_clock_true,
  output logic [2:0]      host_clock_comp,
  output logic            host_clock_oe,
  output logic [6:0]      periph_clock_out,
  output logic [2:0]      periph_free_clock_out,
  output logic            fixed_66_out,
  output logic            selectable_66_48_out,
  output logic [2:0]      buffered_66_outs,
  output logic            usb_48_out,
  output logic            dot_48_out,
  output logic            ref_out,
  output logic            clock_outs_oe
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  // ****************************************
  // Input synchronisers
  // ****************************************
  logic [`CCS_SYNC_W-1:0] pins_s;

  ccs_sync2 u_sync (
    .ref_clk (ref_clk),
    .nrst    (nrst),
    .d       ({serial_clock, serial_data_line_in, power_down_n, host_clock_stop_n,
               periph_clock_stop_n, select_latch_qualifier_n, current_multiplier_select,
               tri_level_select, freq_select, crystal_in, host_pll_clk, pll_66_clk,
               pll_48_clk, bypass_66_in_or_out_in}),
    .q       (pins_s)
  );

  // Named views of the synchronised pins
  wire       scl_s   = pins_s[15];
  wire       sda_s   = pins_s[14];
  wire       run_s   = pins_s[13];
  wire       hstop_s = pins_s[12];
  wire       pstop_s = pins_s[11];
  wire       qual_s  = pins_s[10];
  wire       mult_s  = pins_s[9];
  wire [1:0] lvl_s   = pins_s[8:7];
  wire [1:0] lo_s    = pins_s[6:5];
  wire       xtal_s  = pins_s[4];
  wire       hpll_s  = pins_s[3];
  wire       p66_s   = pins_s[2];
  wire       p48_s   = pins_s[1];
  wire       byp_s   = pins_s[0];

  // ****************************************
  // Select latch and mode decode
  // ****************************************
  logic [1:0] lvl_q;
  logic [1:0] lo_q;
  logic       mult_q;
  logic       pup_q;
  logic [1:0] fill_q;

  wire [1:0] lvl_pup = (lvl_s == `CCS_LVL_MID) ? `CCS_LVL_LO : lvl_s;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      lvl_q  <= `CCS_LVL_LO;
      lo_q   <= 2'h0;
      mult_q <= 1'b0;
      pup_q  <= 1'b0;
      fill_q <= 2'h0;
    end else if (!fill_q[1]) begin
      // Synchronisers still show reset zeros, so wait before the power-up capture
      fill_q <= {fill_q[0], 1'b1};
    end else if (!pup_q) begin
      lvl_q  <= lvl_pup;
      lo_q   <= lo_s;
      mult_q <= mult_s;
      pup_q  <= 1'b1;
    end else if (!qual_s) begin
      lvl_q  <= lvl_s;
      lo_q   <= lo_s;
      mult_q <= mult_s;
    end
  end

  // Middle level with unlisted low bits falls back to tri-state, the safe choice
  function automatic ccs_pkg::ccs_mode_t mode_of(input logic [1:0] lvl, input logic [1:0] lo);
    if (lvl == `CCS_LVL_MID)
      return (lo == `CCS_LOW_TEST) ? ccs_pkg::MD_TEST : ccs_pkg::MD_HIZ;
    else if (lvl == `CCS_LVL_LO)
      return ccs_pkg::MD_FIXED;
    else
      return ccs_pkg::MD_BYPASS;
  endfunction

  ccs_pkg::ccs_mode_t mode;
  assign mode = mode_of(lvl_q, lo_q);

  // Mode flags
  wire tst = (mode == ccs_pkg::MD_TEST);
  wire byp = (mode == ccs_pkg::MD_BYPASS);
  wire hiz = (mode == ccs_pkg::MD_HIZ);

  // host rate code to the PLL
  assign host_freq_code             = lo_q;
  assign current_multiplier_latched = mult_q;

  // ****************************************
  // Dividers
  // ****************************************
  logic       xtal_d_q;
  logic [2:0] tdiv_q;
  logic       a66_d_q;
  logic       pdiv_q;

  wire a66       = byp ? byp_s : p66_s;
  wire xtal_rise = xtal_s & ~xtal_d_q;
  wire a66_rise  = a66 & ~a66_d_q;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      xtal_d_q <= 1'b0;
      tdiv_q   <= 3'h0;
    end else begin
      xtal_d_q <= xtal_s;
      if (!tst) tdiv_q <= 3'h0;
      else if (xtal_rise) tdiv_q <= tdiv_q + 3'h1;
    end
  end

  // PCI at half of 66 source
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      a66_d_q <= 1'b0;
      pdiv_q  <= 1'b0;
    end else begin
      a66_d_q <= a66;
      if (!run_s) pdiv_q <= 1'b0;
      else if (a66_rise) pdiv_q <= ~pdiv_q;
    end
  end

  // ****************************************
  // Source selection
  // ****************************************
  logic [2:0] ctl0_q;
  logic [6:0] ctl1_q;
  logic [7:0] ctl2_q;
  logic [7:0] ctl3_q;

  wire src_host = tst ? tdiv_q[0] : hpll_s;
  wire src_66   = tst ? tdiv_q[1] : p66_s;
  wire src_b66  = tst ? tdiv_q[1] : a66;
  wire src_pci  = tst ? tdiv_q[2] : pdiv_q;
  wire src_48   = tst ? tdiv_q[0] : p48_s;
  // 48 or 66 by serial bit
  wire src_sel  = tst ? tdiv_q[1] : (ctl0_q[`CCS_C0_SEL48] ? p48_s : p66_s);

  // ****************************************
  // Fixed outputs and enables
  // ****************************************
  // outputs stop low in power-down
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      fixed_66_out            <= 1'b0;
      selectable_66_48_out    <= 1'b0;
      buffered_66_outs        <= 3'h0;
      bypass_66_in_or_out_out <= 1'b0;
      usb_48_out              <= 1'b0;
      dot_48_out              <= 1'b0;
      ref_out                 <= 1'b0;
    end else begin
      fixed_66_out            <= run_s & src_66;
      selectable_66_48_out    <= run_s & src_sel;
      buffered_66_outs        <= {3{run_s & src_b66}};
      bypass_66_in_or_out_out <= run_s & src_b66;
      usb_48_out              <= run_s & src_48;
      dot_48_out              <= run_s & src_48;
      ref_out                 <= run_s & xtal_s;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      clock_outs_oe          <= 1'b0;
      bypass_66_in_or_out_oe <= 1'b0;
      host_clock_oe          <= 1'b0;
    end else begin
      clock_outs_oe          <= ~hiz;
      bypass_66_in_or_out_oe <= ~hiz & ~byp;
      host_clock_oe          <= ~hiz & ~(~run_s & ctl0_q[`CCS_C0_PDTRI]);
    end
  end

  // ****************************************
  // Stop gating
  // ****************************************
  // host stop unless free
  wire [2:0] host_run = ({3{hstop_s}} | ctl1_q[5:3]) & ctl1_q[2:0];
  wire       pstop_eff_n = pstop_s & ctl3_q[`CCS_C3_STOP];
  wire [6:0] pci_run  = {7{pstop_eff_n}} & ctl2_q[6:0];
  wire [2:0] pcif_run = {3{pstop_eff_n}} | ctl3_q[5:3];

  // Power-down forces host true high so the PLL can stop cleanly
  ccs_gate #(.N(3), .STOP_LVL(1'b1)) u_host_t (
    .ref_clk (ref_clk),
    .nrst    (nrst),
    .src     (src_host),
    .run     (host_run),
    .frc     (~run_s),
    .frc_val (1'b1),
    .out     (host_clock_true)
  );

  ccs_gate #(.N(3), .STOP_LVL(1'b0)) u_host_c (
    .ref_clk (ref_clk),
    .nrst    (nrst),
    .src     (~src_host),
    .run     (host_run),
    .frc     (~run_s),
    .frc_val (1'b0),
    .out     (host_clock_comp)
  );

  ccs_gate #(.N(7), .STOP_LVL(1'b0)) u_pci (
    .ref_clk (ref_clk),
    .nrst    (nrst),
    .src     (src_pci),
    .run     (pci_run),
    .frc     (~run_s),
    .frc_val (1'b0),
    .out     (periph_clock_out)
  );

  ccs_gate #(.N(3), .STOP_LVL(1'b0)) u_pcif (
    .ref_clk (ref_clk),
    .nrst    (nrst),
    .src     (src_pci),
    .run     (pcif_run),
    .frc     (~run_s),
    .frc_val (1'b0),
    .out     (periph_free_clock_out)
  );

  // ****************************************
  // Two-wire target, alive through power-down
  // ****************************************
  ccs_pkg::ccs_ser_t st_q;
  logic [3:0] bit_q;
  logic [7:0] sh_q;
  logic [7:0] tx_q;
  logic [2:0] idx_q;
  logic       oe_q;
  logic       scl_d_q;
  logic       sda_d_q;

  // Bus events
  wire scl_rise  = scl_s & ~scl_d_q;
  wire scl_fall  = ~scl_s & scl_d_q;
  wire start     = scl_s & scl_d_q & sda_d_q & ~sda_s;
  wire stop      = scl_s & scl_d_q & ~sda_d_q & sda_s;
  wire byte_done = (bit_q == 4'h8);
  wire rd_st     = (st_q == ccs_pkg::SM_RDAT);
  wire acking    = !rd_st && (st_q != ccs_pkg::SM_IDLE);
  wire addr_hit  = (sh_q == `CCS_ADDR_WR) || (sh_q == `CCS_ADDR_RD);
  wire ack_fall  = scl_fall && byte_done;
  wire wr_en     = ack_fall && (st_q == ccs_pkg::SM_WDAT) && !idx_q[2];

  // Read-back bytes; status bits are live
  function automatic logic [7:0] rb(input logic [2:0] i);
    case (i)
      3'h0:    rb = {ctl0_q, hstop_s, pstop_eff_n, lvl_q[1], lo_q};
      3'h1:    rb = {mult_q, ctl1_q};
      3'h2:    rb = ctl2_q;
      3'h3:    rb = ctl3_q;
      default: rb = 8'hff;
    endcase
  endfunction

  // Edge history
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      scl_d_q <= 1'b1;
      sda_d_q <= 1'b1;
    end else begin
      scl_d_q <= scl_s;
      sda_d_q <= sda_s;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      st_q  <= ccs_pkg::SM_IDLE;
      bit_q <= 4'h0;
      sh_q  <= 8'h00;
      tx_q  <= 8'h00;
      idx_q <= 3'h0;
      oe_q  <= 1'b0;
    end else if (start) begin
      st_q  <= ccs_pkg::SM_ADDR;
      bit_q <= 4'h0;
      oe_q  <= 1'b0;
    end else if (stop) begin
      st_q <= ccs_pkg::SM_IDLE;
      oe_q <= 1'b0;
    end else if (st_q != ccs_pkg::SM_IDLE) begin
      if (scl_rise && !byte_done) begin
        sh_q  <= {sh_q[6:0], sda_s};
        bit_q <= bit_q + 4'h1;
      end else if (scl_rise) begin
        bit_q <= 4'h0;
        // Host not-acknowledge ends a read
        if (rd_st && sda_s) st_q <= ccs_pkg::SM_IDLE;
      end else if (ack_fall) begin
        oe_q <= acking && ((st_q != ccs_pkg::SM_ADDR) || addr_hit);
        unique case (st_q)
          ccs_pkg::SM_ADDR: begin
            st_q  <= !addr_hit ? ccs_pkg::SM_IDLE :
                     sh_q[0] ? ccs_pkg::SM_RDAT : ccs_pkg::SM_CMD;
            tx_q  <= rb(3'h0);
            idx_q <= 3'h1;
          end
          ccs_pkg::SM_CMD: st_q <= ccs_pkg::SM_CNT;
          ccs_pkg::SM_CNT: begin
            st_q  <= ccs_pkg::SM_WDAT;
            idx_q <= 3'h0;
          end
          ccs_pkg::SM_WDAT: idx_q <= idx_q[2] ? idx_q : idx_q + 3'h1;
          ccs_pkg::SM_RDAT: begin
            tx_q  <= rb(idx_q);
            idx_q <= idx_q[2] ? idx_q : idx_q + 3'h1;
          end
          default: st_q <= ccs_pkg::SM_IDLE;
        endcase
      end else if (scl_fall) begin
        // Open drain: pull low only for a zero
        oe_q <= rd_st && !tx_q[7];
        if (rd_st) tx_q <= {tx_q[6:0], 1'b0};
      end
    end
  end

  assign serial_data_line_oe  = oe_q;
  assign serial_data_line_out = 1'b0;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      ctl0_q <= `CCS_CTL0_RST;
      ctl1_q <= `CCS_CTL1_RST;
      ctl2_q <= `CCS_CTL2_RST;
      ctl3_q <= `CCS_CTL3_RST;
    end else if (wr_en) begin
      case (idx_q[1:0])
        2'h0:    ctl0_q <= sh_q[7:5];
        2'h1:    ctl1_q <= sh_q[6:0];
        2'h2:    ctl2_q <= sh_q;
        default: ctl3_q <= sh_q;
      endcase
    end
  end

  assign spread_enable    = ctl0_q[`CCS_C0_SPREAD];
  assign ref_low_strength = ctl2_q[`CCS_C2_REFLO];

  // ****************************************
  // Assertions
  // ****************************************
  AST_FREQ_CODE: assert property (pup_q && !qual_s |=> host_freq_code == $past(lo_s))
    else $error("host rate code not latched");
  AST_BYPASS_COPY: assert property (byp && run_s |=> buffered_66_outs == {3{$past(byp_s)}})
    else $error("buffered outputs not copying 66 input");
  AST_FIXED_DRIVE: assert property (mode == ccs_pkg::MD_FIXED |=> bypass_66_in_or_out_oe)
    else $error("shared 66 pin not driven in fixed mode");
  AST_HIZ: assert property (hiz |=> !clock_outs_oe && !host_clock_oe)
    else $error("outputs enabled in tri-state mode");
  AST_TEST_USB: assert property (tst && run_s |=> usb_48_out == $past(tdiv_q[0]))
    else $error("test divide wrong on 48 output");
  AST_PUP_MID: assert property (!pup_q && lvl_s == `CCS_LVL_MID |=> lvl_q == `CCS_LVL_LO)
    else $error("middle level not latched as 0");
  AST_LATCH_HOLD: assert property (pup_q && qual_s |=> $stable(lvl_q) && $stable(lo_q))
    else $error("selects changed with qualifier high");
  AST_PD_QUIET: assert property (!run_s |=> periph_clock_out == 7'h00 && !fixed_66_out)
    else $error("outputs running in power-down");
  AST_HOST_PD: assert property (!run_s && !ctl0_q[`CCS_C0_PDTRI] |=>
                                host_clock_true == 3'h7 && host_clock_comp == 3'h0)
    else $error("host outputs not parked in power-down");
  AST_SEL48: assert property (run_s && !tst && ctl0_q[`CCS_C0_SEL48] |=>
                              selectable_66_48_out == $past(p48_s))
    else $error("selectable output not at 48");
  AST_ADDR_MISS: assert property (st_q == ccs_pkg::SM_ADDR && ack_fall && !addr_hit && !stop |=>
                                  !serial_data_line_oe ##1 st_q == ccs_pkg::SM_IDLE)
    else $error("foreign address acknowledged");

  COV_TEST: cover property (tst && run_s ##1 xtal_rise);
  COV_BYPASS: cover property (byp && run_s && a66_rise);
  COV_WRITE: cover property (wr_en);
  COV_HOST_STOP: cover property (!hstop_s && run_s ##2 !hstop_s);
endmodule

// ### tb/ccs_host_model.sv
// Two-wire host model for the serial control port of the clock block
`timescale 1ns/1ps
module ccs_host_model (
  input  wire logic ref_clk,
  input  wire logic dev_oe,
  output logic      scl,
  output wire logic sda
);
  logic pull;

  // Open-drain line with pull-up, low while either side pulls
  assign sda = ~(pull | dev_oe);

  initial begin
    scl  = 1'b1;
    pull = 1'b0;
  end

  // Four reference cycles per phase so the synchronisers see each level
  task automatic tick();
    repeat (4) @(posedge ref_clk);
    #1;
  endtask

  // Start: data falls while the clock is high
  task automatic start();
    pull = 1'b1;
    tick();
    scl = 1'b0;
    tick();
  endtask

  task automatic send_byte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      pull = ~b[i];
      tick();
      scl = 1'b1;
      tick();
      scl = 1'b0;
      tick();
    end
    pull = 1'b0;
    tick();
    scl = 1'b1;
    tick();
    ack = ~sda;
    scl = 1'b0;
    tick();
  endtask

  // host reads one byte, then answers not-acknowledge
  task automatic recv_byte(output logic [7:0] b);
    pull = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      tick();
      scl = 1'b1;
      tick();
      b[i] = sda;
      scl = 1'b0;
    end
    tick();
    scl = 1'b1;
    tick();
    scl = 1'b0;
    tick();
  endtask

  // Stop: data rises while the clock is high, line then left released
  task automatic stop();
    pull = 1'b1;
    tick();
    scl = 1'b1;
    tick();
    pull = 1'b0;
    tick();
  endtask
endmodule

// ### tb/ccs_clock_ctrl_tb_top.sv
// Self-checking testbench for the clock select and stop control block
`timescale 1ns/1ps
`include "ccs_params.svh"
module ccs_clock_ctrl_tb_top;
  logic       ref_clk = 1'b0;
  logic       nrst = 1'b0;
  logic [3:0] src_q = 4'h0;
  logic       tog = 1'b1;
  logic [1:0] tri_level_select = `CCS_LVL_MID;
  logic [1:0] freq_select = 2'h1;
  logic       qual_n = 1'b1;
  logic       power_down_n = 1'b1;
  logic       host_stop_n = 1'b1;
  logic       pci_stop_n = 1'b1;
  logic       bp_in = 1'b0;
  logic       mult = 1'b1;
  logic       mult_l;
  logic       h_oe;
  logic       bp_out;
  logic       ref_low;
  logic       scl;
  wire        sda;
  logic       sda_oe;
  logic       bp_oe;
  logic       clk_oe;
  logic       spread;
  logic       sel_out;
  logic       fixed_out;
  logic       usb_out;
  logic       dot_out;
  logic       ref_o;
  logic [1:0] hf_code;
  logic [2:0] ht;
  logic [2:0] hc;
  logic [2:0] pcif;
  logic [2:0] b66;
  logic [6:0] pci;
  int         error_cnt = 0;
  int         n_checks = 0;

  always #20 ref_clk = ~ref_clk;

  // Counter stand-ins for the crystal and the PLL outputs, held at 4 while tog is low
  always @(posedge ref_clk) begin
    #1;
    if (tog) begin
      src_q <= src_q + 4'h1;
    end else begin
      src_q <= 4'h4;
    end
  end

  ccs_host_model host (.ref_clk(ref_clk), .dev_oe(sda_oe), .scl(scl), .sda(sda));

  ccs_clock_ctrl uut (
    .ref_clk(ref_clk), .nrst(nrst), .crystal_in(src_q[0]), .host_pll_clk(src_q[0]),
    .pll_66_clk(src_q[1]), .pll_48_clk(src_q[2]), .tri_level_select(tri_level_select),
    .freq_select(freq_select), .current_multiplier_select(mult),
    .select_latch_qualifier_n(qual_n), .power_down_n(power_down_n),
    .host_clock_stop_n(host_stop_n), .periph_clock_stop_n(pci_stop_n),
    .serial_clock(scl), .serial_data_line_in(sda), .serial_data_line_out(),
    .serial_data_line_oe(sda_oe), .bypass_66_in_or_out_in(bp_in),
    .bypass_66_in_or_out_out(bp_out), .bypass_66_in_or_out_oe(bp_oe), .host_freq_code(hf_code),
    .current_multiplier_latched(mult_l), .spread_enable(spread), .ref_low_strength(ref_low),
    .host_clock_true(ht), .host_clock_comp(hc), .host_clock_oe(h_oe),
    .periph_clock_out(pci), .periph_free_clock_out(pcif), .fixed_66_out(fixed_out),
    .selectable_66_48_out(sel_out), .buffered_66_outs(b66), .usb_48_out(usb_out),
    .dot_48_out(dot_out), .ref_out(ref_o), .clock_outs_oe(clk_oe)
  );

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Select decode in bypass mode, then hold with the qualifier high
  task automatic t_select();
    logic [3:0] prev;
    logic [3:0] cur;
    int         n [4];
    qual_n = 1'b0;
    mult = 1'b0;
    tri_level_select = `CCS_LVL_HI;
    for (int f = 0; f < 4; f++) begin
      freq_select = f[1:0];
      cyc(6);
      chk({6'h0, hf_code}, f[7:0], "freq code");
    end
    bp_in = 1'b1;
    cyc(6);
    chk({4'h0, b66, bp_oe}, 8'h0e, "bypass copy");
    bp_in = 1'b0;
    qual_n = 1'b1;
    mult = 1'b1;
    tri_level_select = `CCS_LVL_LO;
    freq_select = 2'h0;
    cyc(6);
    chk({4'h0, mult_l, hf_code, bp_oe}, 8'h06, "held select");
    qual_n = 1'b0;
    cyc(6);
    chk({6'h0, bp_out ^ fixed_out, bp_oe}, 8'h01, "fixed mode pin");
    tri_level_select = `CCS_LVL_MID;
    cyc(6);
    chk({6'h0, clk_oe, h_oe}, 8'h00, "hi-z mode");
    // Test mode: rising edges per group over 64 cycles, whole periods only
    freq_select = `CCS_LOW_TEST;
    cyc(24);
    n = '{0, 0, 0, 0};
    prev = {ref_o, usb_out, fixed_out, pci[0]};
    for (int i = 0; i < 64; i++) begin
      cyc(1);
      cur = {ref_o, usb_out, fixed_out, pci[0]};
      for (int j = 0; j < 4; j++) begin
        if (cur[j] && !prev[j]) begin
          n[j]++;
        end
      end
      prev = cur;
    end
    chk(n[3][7:0], 8'h20, "test ref");
    chk(n[2][7:0], 8'h10, "test 48");
    chk(n[1][7:0], 8'h08, "test 66");
    chk(n[0][7:0], 8'h04, "test pci");
    tri_level_select = `CCS_LVL_LO;
    cyc(6);
    $display("select test done");
  endtask

  // Peripheral clocks run, then stop low; host pair stops true high
  task automatic t_stops();
    logic seen;
    seen = 1'b0;
    for (int i = 0; i < 40; i++) begin
      if (pci !== 7'h00) begin
        seen = 1'b1;
      end
      cyc(1);
    end
    chk({7'h0, seen}, 8'h01, "pci running");
    pci_stop_n = 1'b0;
    host_stop_n = 1'b0;
    cyc(12);
    for (int i = 0; i < 20; i++) begin
      chk({1'b0, pci}, 8'h00, "pci stopped");
      chk({2'h0, ht, hc}, 8'h38, "host stopped");
      chk({5'h0, pcif}, 8'h00, "pcif stopped");
      cyc(1);
    end
    pci_stop_n = 1'b1;
    host_stop_n = 1'b1;
    cyc(12);
    $display("stop test done");
  endtask

  // Serial write to the write address, then a foreign address
  task automatic t_serial();
    logic ack;
    logic [7:0] rd;
    tog = 1'b0;
    cyc(8);
    chk({7'h0, sel_out}, 8'h00, "66 by default");
    host.start();
    host.send_byte(`CCS_ADDR_WR, ack);
    chk({7'h0, ack}, 8'h01, "address ack");
    host.send_byte(8'h00, ack);
    host.send_byte(8'h01, ack);
    host.send_byte(8'ha0, ack);
    chk({7'h0, ack}, 8'h01, "data ack");
    host.send_byte(8'h07, ack);
    host.send_byte(8'hff, ack);
    chk({7'h0, ack}, 8'h01, "third data ack");
    host.stop();
    cyc(8);
    chk({5'h0, ref_low, spread, sel_out}, 8'h07, "written control");
    host.start();
    host.send_byte(`CCS_ADDR_RD, ack);
    host.recv_byte(rd);
    host.stop();
    chk(rd, 8'hb9, "read byte 0");
    host.start();
    host.send_byte(8'hd4, ack);
    chk({7'h0, ack}, 8'h00, "foreign address");
    host.stop();
    tog = 1'b1;
    $display("serial test done");
  endtask

  // Power-down stops the outputs, host true high and complement low
  task automatic t_power_down();
    power_down_n = 1'b0;
    cyc(8);
    chk({pci, fixed_out}, 8'h00, "pd pci");
    chk({2'h0, usb_out, dot_out, ref_o, b66}, 8'h00, "pd misc");
    chk({1'b0, h_oe, ht, hc}, 8'h78, "pd host");
    power_down_n = 1'b1;
    cyc(8);
    $display("power-down test done");
  endtask

  // Watchdog well beyond the roughly 1300 cycles the tests need
  initial begin
    repeat (20000) @(posedge ref_clk);
    error_cnt++;
    end_sim();
  end

  initial begin
    repeat (12) @(posedge ref_clk);
    #1;
    nrst = 1'b1;
    cyc(8);
    chk({5'h0, mult_l, bp_oe, clk_oe}, 8'h07, "power-up middle");
    t_select();
    t_stops();
    t_serial();
    t_power_down();
    end_sim();
  end
endmodule
